// ===== rtl/scd_pkg.sv
// Package for the power-up switch configuration decoder.
// Assumes one 20 MHz system clock and a synchronous active-low reset.
package scd_pkg;

    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned FLASH_MS      = 250;
    localparam int unsigned FLASH_CYC     = (CLK_HZ / 1000) * FLASH_MS;
    localparam int unsigned SETTLE_US     = 10;
    localparam int unsigned SETTLE_CYC    = (CLK_HZ / 1_000_000) * SETTLE_US;
    localparam int unsigned CNT_W         = 24;

    // Switch positions within the 8-bit switch vector (bit 0 = switch 1)
    localparam int unsigned SW_TEST       = 0;
    localparam int unsigned SW_BAUD_HI    = 1;
    localparam int unsigned SW_BAUD_LO    = 2;
    localparam int unsigned SW_ADDR_MSB   = 3;
    localparam int unsigned SW_ADDR_LSB   = 7;
    localparam int unsigned ADDR_W        = 5;

    localparam int unsigned MAX_MASTERS   = 31;
    localparam int unsigned MAX_SLAVES    = 15;
    localparam int unsigned MAX_CHANNELS  = 16;

    typedef enum logic [1:0] {
        SCD_BAUD_9600  = 2'b00,
        SCD_BAUD_19200 = 2'b01,
        SCD_BAUD_38400 = 2'b10,
        SCD_BAUD_BAD   = 2'b11
    } scd_baud_t;

    typedef enum logic [1:0] {
        SCD_ST_SETTLE = 2'b00,
        SCD_ST_INIT   = 2'b01,
        SCD_ST_RUN    = 2'b10,
        SCD_ST_TEST   = 2'b11
    } scd_state_t;

    typedef struct packed {
        logic       test_mode;
        scd_baud_t  baud;
        logic [4:0] addr;
        logic       link_en;
        logic       cfg_err;
    } scd_cfg_t;

    // LED vector: bit 2 red, bit 1 orange, bit 0 green
    typedef struct packed {
        logic red;
        logic orange;
        logic green;
    } scd_led_t;

    localparam scd_cfg_t CFG_RST = '{1'b0, SCD_BAUD_9600, 5'h00, 1'b0, 1'b0};
    localparam scd_led_t LED_OFF = '{1'b0, 1'b0, 1'b0};

endpackage

// ===== rtl/scd_switch_config_decoder.sv
// Power-up switch decoder: latches the eight switches once after reset
// and drives LED pattern, baud select, station address and link enable.
// Assumes rst_n_i is held low by a power-on reset; switches are pins.
`timescale 1ns/1ps

module scd_switch_config_decoder
    import scd_pkg::*;
#(
    parameter int unsigned FLASH_CYCLES  = FLASH_CYC,
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
    parameter int unsigned INIT_FLASHES  = 4
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] switch_i,
    input  wire logic       init_done_i,
    output logic            cfg_valid_o,
    output scd_cfg_t        cfg_o,
    output scd_led_t        led_o,
    output logic [4:0]      max_slaves_o,
    output logic [4:0]      max_channels_o
);

    function automatic scd_baud_t decode_baud(input logic [7:0] sw);
        return scd_baud_t'({sw[SW_BAUD_HI], sw[SW_BAUD_LO]});
    endfunction

    function automatic logic [ADDR_W-1:0] decode_addr(input logic [7:0] sw);
        return sw[SW_ADDR_LSB:SW_ADDR_MSB] == '0 ? '0 :
            {sw[SW_ADDR_MSB], sw[SW_ADDR_MSB+1], sw[SW_ADDR_MSB+2],
             sw[SW_ADDR_MSB+3], sw[SW_ADDR_LSB]};
    endfunction

    // Two-stage synchroniser for the switch pins
    logic [7:0] sw_meta_q, sw_sync_q;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sw_meta_q <= 8'h00;
            sw_sync_q <= 8'h00;
        end else begin
            sw_meta_q <= switch_i;
            sw_sync_q <= sw_meta_q;
        end
    end

    scd_state_t       state_q, state_d;
    scd_cfg_t         cfg_q, cfg_d;
    scd_led_t         led_q, led_d;
    logic             valid_q, valid_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [1:0]       phase_q, phase_d;
    logic [3:0]       nflash_q, nflash_d;
    logic             tick;

    assign tick = (cnt_q == CNT_W'(FLASH_CYCLES - 1));

    always_comb begin
        state_d  = state_q;
        cfg_d    = cfg_q;
        led_d    = led_q;
        valid_d  = valid_q;
        cnt_d    = tick ? '0 : cnt_q + CNT_W'(1);
        phase_d  = phase_q;
        nflash_d = nflash_q;
        case (state_q)
            SCD_ST_SETTLE: begin
                // Wait for the synchroniser and pin bounce before latching
                led_d = LED_OFF;
                if (cnt_q == CNT_W'(SETTLE_CYCLES - 1)) begin
                    cnt_d = '0;
                    cfg_d.test_mode = sw_sync_q[SW_TEST];
                    cfg_d.baud      = decode_baud(sw_sync_q);
                    cfg_d.addr      = decode_addr(sw_sync_q);
                    cfg_d.cfg_err   = decode_baud(sw_sync_q) == SCD_BAUD_BAD;
                    cfg_d.link_en   = 1'b0;
                    valid_d = 1'b1;
                    state_d = SCD_ST_INIT;
                end
            end
            SCD_ST_INIT: begin
                // Green blinks, red reports a bad baud setting
                led_d.orange = 1'b0;
                led_d.red    = cfg_q.cfg_err;
                if (tick) begin
                    led_d.green = ~led_q.green;
                    // Saturate so a late self-test cannot wrap the count
                    if (nflash_q < 4'(INIT_FLASHES)) begin
                        nflash_d = nflash_q + 4'(1);
                    end
                end
                if (nflash_q >= 4'(INIT_FLASHES) && init_done_i) begin
                    state_d = cfg_q.test_mode ? SCD_ST_TEST : SCD_ST_RUN;
                    led_d   = LED_OFF;
                    phase_d = 2'b00;
                    cfg_d.link_en = ~cfg_q.cfg_err && ~cfg_q.test_mode;
                end
            end
            SCD_ST_RUN: begin
                led_d.green  = 1'b1;
                led_d.orange = 1'b0;
                led_d.red    = cfg_q.cfg_err;
            end
            SCD_ST_TEST: begin
                if (tick) begin
                    phase_d = (phase_q == 2'b10) ? 2'b00 : phase_q + 2'b01;
                end
                led_d.green  = (phase_q == 2'b00);
                led_d.orange = (phase_q == 2'b01);
                led_d.red    = (phase_q == 2'b10);
            end
            default: state_d = SCD_ST_SETTLE;
        endcase
    end

    // Switch-derived configuration is only written in SETTLE (INIT sets only link_en),
    // so later switch moves cannot reach it until reset is asserted again.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_q  <= SCD_ST_SETTLE;
            cfg_q    <= CFG_RST;
            led_q    <= LED_OFF;
            valid_q  <= 1'b0;
            cnt_q    <= '0;
            phase_q  <= 2'b00;
            nflash_q <= 4'h0;
        end else begin
            state_q  <= state_d;
            cfg_q    <= cfg_d;
            led_q    <= led_d;
            valid_q  <= valid_d;
            cnt_q    <= cnt_d;
            phase_q  <= phase_d;
            nflash_q <= nflash_d;
        end
    end

    // System limits reported to the rest of the device
    logic [4:0] max_slaves_q, max_channels_q;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            max_slaves_q   <= 5'h00;
            max_channels_q <= 5'h00;
        end else begin
            max_slaves_q   <= 5'(MAX_SLAVES);
            max_channels_q <= 5'(MAX_CHANNELS);
        end
    end

    assign cfg_valid_o    = valid_q;
    assign cfg_o          = cfg_q;
    assign led_o          = led_q;
    assign max_slaves_o   = max_slaves_q;
    assign max_channels_o = max_channels_q;

    // Assertions
    property p_latch_hold;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (valid_q && $past(valid_q)) |-> $stable(cfg_q.addr) && $stable(cfg_q.baud);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("Config changed after power-up latch");

    property p_addr;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_q == SCD_ST_SETTLE && state_d == SCD_ST_INIT) |=>
            cfg_q.addr == {$past(sw_sync_q[3]), $past(sw_sync_q[4]),
                $past(sw_sync_q[5]), $past(sw_sync_q[6]), $past(sw_sync_q[7])};
    endproperty
    a_addr: assert property (p_addr)
        else $error("Station address does not match switch weights");

    property p_baud;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(valid_q) |-> cfg_q.baud == scd_baud_t'({$past(sw_sync_q[1]),
            $past(sw_sync_q[2])});
    endproperty
    a_baud: assert property (p_baud)
        else $error("Baud select does not match switches");

    property p_err_link;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_q.cfg_err |-> !cfg_q.link_en && (state_q == SCD_ST_SETTLE || led_q.red
            || state_q == SCD_ST_TEST || $past(state_q) != state_q);
    endproperty
    a_err_link: assert property (p_err_link)
        else $error("Bad baud setting left link enabled or red dark");

    property p_init_led;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_q == SCD_ST_INIT && $past(state_q) == SCD_ST_INIT) |->
            !led_q.orange && led_q.red == cfg_q.cfg_err;
    endproperty
    a_init_led: assert property (p_init_led)
        else $error("Init LEDs wrong");

    sequence s_one_hot;
        $onehot(led_q);
    endsequence
    property p_test_led;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_q == SCD_ST_TEST && $past(state_q) == SCD_ST_TEST) |-> s_one_hot;
    endproperty
    a_test_led: assert property (p_test_led)
        else $error("Test mode must light exactly one LED");

    property p_normal;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (valid_q && !cfg_q.test_mode) |-> state_q != SCD_ST_TEST;
    endproperty
    a_normal: assert property (p_normal)
        else $error("LED test entered with test switch off");

    property p_default;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ($rose(valid_q) && $past(sw_sync_q) == 8'h00) |->
            !cfg_q.test_mode && cfg_q.baud == SCD_BAUD_9600 && cfg_q.addr == 5'h00;
    endproperty
    a_default: assert property (p_default)
        else $error("Delivery defaults wrong");

    property p_limits;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        valid_q |-> max_slaves_o == 5'h0F && max_channels_o == 5'h10;
    endproperty
    a_limits: assert property (p_limits)
        else $error("System limits wrong");

endmodule // scd_switch_config_decoder

// ===== verification/scd_switch_model.sv
// Installer side: holds the eight front-panel switches and the self-test
// done level. The bench calls set_switches while reset is low, and again after the latch.
`timescale 1ns/1ps
module scd_switch_model (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    output logic [7:0]      switch_o,
    output logic            init_done_o
);
    int unsigned init_wait = 2;
    int unsigned cnt_q     = 0;
    initial switch_o = 8'h00;
    // One station on the bus here, so its address is distinct by itself
    task automatic set_switches(input logic [7:0] v,
                                input int unsigned w);
        @(posedge ref_clk_i);
        switch_o  <= v;
        init_wait <= w;
    endtask
    // Self-test may finish promptly or late; w sets how late
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) cnt_q <= 0;
        else if (cnt_q < init_wait) cnt_q <= cnt_q + 1;
    end
    // Only level inputs reach the device; nothing talks on the link unasked
    assign init_done_o = rst_n_i && (cnt_q >= init_wait);
endmodule // scd_switch_model

// ===== verification/testbench.sv
// Self-checking bench for the switch decoder with short flash counts.
// Assumes the installer model supplies switches and self-test done.
`timescale 1ns/1ps
module testbench;
    import scd_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic [7:0]  switch_i;
    logic        init_done_i;
    logic        cfg_valid_o;
    scd_cfg_t    cfg_o;
    scd_led_t    led_o;
    logic [4:0]  max_slaves_o;
    logic [4:0]  max_channels_o;
    int unsigned failures = 0;
    int unsigned n_checks = 0;
    int unsigned cycles   = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    scd_switch_config_decoder #(.FLASH_CYCLES(4), .SETTLE_CYCLES(4),
        .INIT_FLASHES(4)) u_scd_switch_config_decoder (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .switch_i(switch_i),
        .init_done_i(init_done_i), .cfg_valid_o(cfg_valid_o),
        .cfg_o(cfg_o), .led_o(led_o), .max_slaves_o(max_slaves_o),
        .max_channels_o(max_channels_o));
    scd_switch_model u_scd_switch_model (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .switch_o(switch_i), .init_done_o(init_done_i));
    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Whole run needs well under 2000 cycles
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_cfg(input scd_cfg_t g, e); cmp(g, e); endtask
    task automatic cmp_led(input scd_led_t g, e);
        cmp({7'h00, g}, {7'h00, e});
    endtask
    task automatic cmp_num(input logic [4:0] g, e);
        cmp({5'h00, g}, {5'h00, e});
    endtask
    task automatic cmp_bit(input logic g, e);
        cmp({9'h000, g}, {9'h000, e});
    endtask
    function automatic scd_cfg_t exp_cfg(input logic [7:0] sw, input up);
        scd_cfg_t c;
        int a;
        a = 0;
        for (int k = 0; k < 5; k++) if (sw[3+k]) a += 16 >> k;
        c.test_mode = sw[0];
        c.baud      = scd_baud_t'({sw[1], sw[2]});
        c.addr      = a[4:0];
        c.cfg_err   = sw[1] & sw[2];
        c.link_en   = up & ~c.cfg_err & ~sw[0];
        return c;
    endfunction
    task automatic power_up(input logic [7:0] sw, input int unsigned w);
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        u_scd_switch_model.set_switches(sw, w);
        repeat (4) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(negedge ref_clk_i);
        cmp_bit(cfg_valid_o, 1'b0);
        for (int i = 0; i < 20 && cfg_valid_o !== 1'b1; i++)
            @(negedge ref_clk_i);
        cmp_bit(cfg_valid_o, 1'b1);
        cmp_cfg(cfg_o, exp_cfg(sw, 1'b0));
    endtask
    task automatic t_normal(input logic [7:0] sw, input int unsigned w);
        power_up(sw, w);
        for (int i = 0; i < 80 && cfg_o.link_en !== 1'b1; i++) begin
            cmp_led(scd_led_t'(led_o & 3'b110), LED_OFF);
            @(negedge ref_clk_i);
        end
        cmp_cfg(cfg_o, exp_cfg(sw, 1'b1));
        repeat (2) @(negedge ref_clk_i);
        cmp_led(led_o, 3'b001);
        u_scd_switch_model.set_switches(~sw, w);
        repeat (10) @(negedge ref_clk_i);
        cmp_cfg(cfg_o, exp_cfg(sw, 1'b1));
        cmp_num(max_slaves_o, 5'h0f);
        cmp_num(max_channels_o, 5'h10);
    endtask
    task automatic t_error(input logic [7:0] sw);
        power_up(sw, 3);
        repeat (40) @(negedge ref_clk_i);
        cmp_cfg(cfg_o, exp_cfg(sw, 1'b1));
        cmp_led(scd_led_t'(led_o & 3'b100), 3'b100);
    endtask
    task automatic t_test(input logic [7:0] sw);
        scd_led_t seen;
        seen = LED_OFF;
        power_up(sw, 3);
        repeat (30) @(negedge ref_clk_i);
        repeat (24) begin
            @(negedge ref_clk_i);
            cmp_num(5'($countones(led_o)), 5'h01);
            seen = seen | led_o;
        end
        cmp_led(seen, 3'b111);
        cmp_cfg(cfg_o, exp_cfg(sw, 1'b1));
    endtask
    initial begin
        t_normal(8'h00, 3);
        t_normal(8'hb4, 3);
        t_normal(8'hfa, 40);
        t_normal(8'h08, 0);
        t_error(8'h4e);
        t_test(8'h01);
        report_and_stop();
    end
endmodule // testbench
